/* File: logic/melody_buzzer_driver.sv */
// melody and buzzer tone driver with avalon register port and note fetch port
// Behaviour
// - start instruction begins play at current tempo
// - note words fetched in sequence from start
// - end bit note raises interrupt, then stops
// - restart during end note waits for it to finish, then fetches
// - control bit 3 shows playing status
// - writing zero to control bit 3 forces stop
// - tempo code zero acts as code one
// - end bit 15, duration 13:8, pitch 6:0
// - pitch N gives 65536/(N+2) hertz
// - pitch bits 6:2 zero means silence
// - duration is unit times (tempo+1)(code+1)
// - duration code zero acts as one
// - note playing at restart may shorten
// - buzzer enable sends buzzer to pins
// - buzzer carrier 4 kHz, half duty
// - pattern one gated by 8 Hz tap
// - pattern two: 8 Hz and low 1 Hz
// - single beep ends second 32 Hz fall
// - continuous mode sounds while enabled
// - melody silences buzzer, start clears enable
// - reset clears status, enable, pattern bits
`timescale 1ns/1ps
`default_nettype none
`include "melody_params.svh"
module melody_buzzer_driver
  import melody_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // avalon-mm slave, word addressed
  input wire logic [1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // melody start from the cpu, with start address
  input wire logic i_melody_start_instruction,
  input wire logic [`ROM_AW-1:0] i_start_addr,
  // program memory fetch port
  output logic o_rom_req,
  output logic [`ROM_AW-1:0] o_rom_addr,
  input wire logic i_rom_valid,
  input wire logic [15:0] i_rom_data,
  // time base taps, from another divider domain
  input wire logic i_tap_8hz,
  input wire logic i_tap_1hz,
  input wire logic i_tap_32hz,
  // outputs
  output logic o_melody_end_irq,
  output logic o_sounder_out_pin,
  output logic o_sounder_out_inv_pin
);
  // register state
  logic [3:0] beat_rate_reg; // beat_rate_ctrl
  logic playing_status_flag_reg;
  logic buzzer_enable_bit_reg;
  logic [1:0] buzz_pattern_reg; // {buzz_pattern_hi, buzz_pattern_lo}
  play_state_t state_reg;
  logic [`ROM_AW-1:0] fetch_addr_reg; // next word to fetch
  logic next_valid_reg; // a fetched word waits in the holder
  logic [15:0] next_word; // prefetched word
  logic [15:0] cur_word_reg; // note now sounding
  logic [31:0] dur_cnt_reg; // cycles left in current note
  logic last_playing_reg; // current note carries the end bit
  logic pending_start_reg; // restart requested after end note
  logic [`ROM_AW-1:0] pending_addr_reg;
  logic irq_reg;
  // tap synchronisers, first stage read only by second
  logic [2:0] tap_s1_reg;
  logic [2:0] tap_s2_reg;
  logic [2:0] tap_d_reg; // previous synced level for edges
  logic [1:0] fall32_cnt_reg; // 32 Hz falls seen while buzzer enabled, stops at 2
  logic buzz_en_d_reg;
  logic rd_ack_reg; // read word already registered, answer this cycle

  // avalon decode; a read waits one cycle so registered data stand when taken
  wire wr_beat = i_write && (i_address == `ADDR_BEAT_RATE);
  wire wr_ctrl = i_write && (i_address == `ADDR_CTRL);
  wire sw_start = i_write && (i_address == `ADDR_START) && i_writedata[0];
  wire start_req = i_melody_start_instruction || sw_start;
  wire [`ROM_AW-1:0] start_addr = i_melody_start_instruction ? i_start_addr
                                  : i_writedata[`ROM_AW+3:4];
  wire sw_stop = wr_ctrl && !i_writedata[`CTRL_PLAY_BIT] && playing_status_flag_reg;
  assign o_waitrequest = !i_ce || (i_read && !rd_ack_reg);

  // tempo code zero behaves as code one
  function automatic logic [3:0] eff_tempo(input logic [3:0] code);
    eff_tempo = (code == 4'h0) ? 4'h1 : code;
  endfunction
  // duration code zero behaves as code one
  function automatic logic [5:0] eff_dur(input logic [5:0] code);
    eff_dur = (code == 6'h00) ? 6'h01 : code;
  endfunction
  // note length in clock cycles; unit time rounded to whole cycles
  function automatic logic [31:0] note_cycles(input logic [3:0] tp, input logic [15:0] w);
    logic [31:0] prod;
    prod = (32'(eff_tempo(tp)) + 32'h1) * (32'(eff_dur(w[`NOTE_DUR_HI:`NOTE_DUR_LO])) + 32'h1);
    note_cycles = 32'(prod * 32'(`UNIT_CYCLES));
  endfunction

  // current note fields
  wire [6:0] pitch_code = cur_word_reg[`NOTE_PITCH_HI:0];
  wire pitch_silent = (pitch_code[6:2] == 5'h00);
  // half period of 65536/(N+2) Hz at the clock rate
  wire [23:0] pitch_half = 24'(({17'h00000, pitch_code} + 24'h000002) * 24'(`PITCH_HALF_CYCLES));
  wire note_done = (state_reg == play) && (dur_cnt_reg <= 32'h00000001);
  wire melody_tone;
  wire carrier;

  note_word_reg u_next
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_wr(o_rom_req && i_rom_valid),
    .i_data(i_rom_data),
    .o_data(next_word)
  );

  tone_divider u_pitch
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_run(state_reg == play && !pitch_silent),
    .i_half(pitch_half),
    .o_wave(melody_tone)
  );

  tone_divider u_carrier
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_run(buzzer_enable_bit_reg),
    .i_half(24'(`CARRIER_HALF_CYCLES)),
    .o_wave(carrier)
  );

  // fetch port: ask while the holder is empty, a melody runs and no end note plays
  assign o_rom_req = playing_status_flag_reg && !next_valid_reg
                     && !last_playing_reg && (state_reg != idle);
  assign o_rom_addr = fetch_addr_reg;

  // playback sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_reg <= idle;
      fetch_addr_reg <= '0;
      next_valid_reg <= 1'b0;
      cur_word_reg <= 16'h0000;
      dur_cnt_reg <= 32'h00000000;
      last_playing_reg <= 1'b0;
      pending_start_reg <= 1'b0;
      pending_addr_reg <= '0;
      irq_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      irq_reg <= 1'b0;
      if (o_rom_req && i_rom_valid)
      begin
        next_valid_reg <= 1'b1;
        fetch_addr_reg <= fetch_addr_reg + 1'b1;
      end
      if (sw_stop)
      begin
        // forced stop drops position; only a new start resumes
        state_reg <= idle;
        next_valid_reg <= 1'b0;
        last_playing_reg <= 1'b0;
        pending_start_reg <= 1'b0;
      end
      else if (start_req && last_playing_reg)
      begin
        // restart during end note: finish it, then chain on
        pending_start_reg <= 1'b1;
        pending_addr_reg <= start_addr;
      end
      else if (start_req)
      begin
        // start cuts the current note short, so it may lose a little
        state_reg <= fetch;
        fetch_addr_reg <= start_addr;
        next_valid_reg <= 1'b0;
        pending_start_reg <= 1'b0;
      end
      else if (state_reg == fetch && next_valid_reg)
      begin
        cur_word_reg <= next_word;
        dur_cnt_reg <= note_cycles(beat_rate_reg, next_word);
        last_playing_reg <= next_word[`NOTE_END_BIT];
        irq_reg <= next_word[`NOTE_END_BIT];
        next_valid_reg <= 1'b0;
        state_reg <= play;
      end
      else if (note_done)
      begin
        if (last_playing_reg && pending_start_reg)
        begin
          state_reg <= fetch;
          fetch_addr_reg <= pending_addr_reg;
          next_valid_reg <= 1'b0;
          pending_start_reg <= 1'b0;
          last_playing_reg <= 1'b0;
        end
        else if (last_playing_reg)
        begin
          state_reg <= idle;
          last_playing_reg <= 1'b0;
        end
        else if (next_valid_reg)
        begin
          // back to back notes with no gap
          cur_word_reg <= next_word;
          dur_cnt_reg <= note_cycles(beat_rate_reg, next_word);
          last_playing_reg <= next_word[`NOTE_END_BIT];
          irq_reg <= next_word[`NOTE_END_BIT];
          next_valid_reg <= 1'b0;
        end
        else
          state_reg <= fetch; // memory was slow, wait for the word
      end
      else if (state_reg == play)
        dur_cnt_reg <= dur_cnt_reg - 32'h00000001;
    end
  end

  // playing flag: set by start, cleared at end or by software
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      playing_status_flag_reg <= 1'b0;
    else if (i_ce)
    begin
      if (start_req)
        playing_status_flag_reg <= 1'b1;
      else if (sw_stop)
        playing_status_flag_reg <= 1'b0;
      else if (note_done && last_playing_reg && !pending_start_reg)
        playing_status_flag_reg <= 1'b0;
    end
  end

  // tap synchronisers and edge memory
  wire [2:0] taps_in = {i_tap_32hz, i_tap_1hz, i_tap_8hz};
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      tap_s1_reg <= 3'h0;
      tap_s2_reg <= 3'h0;
      tap_d_reg <= 3'h0;
    end
    else if (i_ce)
    begin
      tap_s1_reg <= taps_in;
      tap_s2_reg <= tap_s1_reg;
      tap_d_reg <= tap_s2_reg;
    end
  end
  wire fall_32 = tap_d_reg[2] && !tap_s2_reg[2];
  wire beep_mode = (buzz_mode_t'(buzz_pattern_reg) == single_beep);
  wire beep_over = beep_mode && buzzer_enable_bit_reg && fall_32 && (fall32_cnt_reg == 2'h1);

  // control register and beep counter; hardware clear beats software set
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      beat_rate_reg <= `BEAT_RATE_RESET;
      buzzer_enable_bit_reg <= 1'b0;
      buzz_pattern_reg <= 2'h0;
      fall32_cnt_reg <= 2'h0;
      buzz_en_d_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      buzz_en_d_reg <= buzzer_enable_bit_reg;
      if (wr_beat)
        beat_rate_reg <= i_writedata[3:0];
      if (wr_ctrl)
        buzz_pattern_reg <= i_writedata[1:0];
      if (start_req)
        buzzer_enable_bit_reg <= 1'b0;
      else if (beep_over)
        buzzer_enable_bit_reg <= 1'b0;
      else if (wr_ctrl)
        buzzer_enable_bit_reg <= i_writedata[`CTRL_BUZZ_EN_BIT];
      // counting restarts on each rising edge of enable
      if (buzzer_enable_bit_reg && !buzz_en_d_reg)
        fall32_cnt_reg <= 2'h0;
      else if (buzzer_enable_bit_reg && fall_32 && fall32_cnt_reg != 2'h2)
        fall32_cnt_reg <= fall32_cnt_reg + 2'h1;
    end
  end

  // pattern gate from time base taps
  wire gate_8 = tap_s2_reg[0];
  wire gate_1_low = !tap_s2_reg[1];
  logic buzz_gate;
  always_comb
  begin
    unique case (buzz_mode_t'(buzz_pattern_reg))
      intermittent_1: buzz_gate = gate_8;
      intermittent_2: buzz_gate = gate_8 && gate_1_low;
      single_beep: buzz_gate = 1'b1;
      continuous: buzz_gate = 1'b1;
    endcase
  end
  // melody has priority; buzzer muted while playing
  wire buzz_on = buzzer_enable_bit_reg && !playing_status_flag_reg && buzz_gate;
  wire mel_on = (state_reg == play) && !pitch_silent;
  wire wave = mel_on ? melody_tone : (buzz_on && carrier);
  wire active = mel_on || buzz_on;

  // pins and interrupt from flip-flops; idle leaves both low
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_sounder_out_pin <= 1'b0;
      o_sounder_out_inv_pin <= 1'b0;
      o_melody_end_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      o_sounder_out_pin <= active && wave;
      o_sounder_out_inv_pin <= active && !wave;
      o_melody_end_irq <= irq_reg;
    end
  end

  // read data register
  wire [31:0] ctrl_rd = {28'h0000000, playing_status_flag_reg, buzzer_enable_bit_reg,
                         buzz_pattern_reg};
  wire [31:0] status_rd = {29'h00000000, next_valid_reg, last_playing_reg,
                           state_reg == play};
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_readdata <= 32'h00000000;
      rd_ack_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      rd_ack_reg <= i_read && !rd_ack_reg;
      if (i_read)
        unique case (i_address)
          `ADDR_BEAT_RATE: o_readdata <= {28'h0000000, beat_rate_reg};
          `ADDR_CTRL: o_readdata <= ctrl_rd;
          `ADDR_STATUS: o_readdata <= status_rd;
          default: o_readdata <= 32'h00000000;
        endcase
    end
  end
endmodule
`default_nettype wire

/* File: logic/melody_params.svh */
// constants for the melody and buzzer driver
`ifndef MELODY_PARAMS_SVH
`define MELODY_PARAMS_SVH
`define ADDR_BEAT_RATE 2'h0
`define ADDR_CTRL 2'h1
`define ADDR_START 2'h2
`define ADDR_STATUS 2'h3
`define CTRL_PLAY_BIT 3
`define CTRL_BUZZ_EN_BIT 2
`define NOTE_END_BIT 15
`define NOTE_DUR_HI 13
`define NOTE_DUR_LO 8
`define NOTE_PITCH_HI 6
`define BEAT_RATE_RESET 4'h0
`define CTRL_RESET 4'h0
`define CLK_HZ 125000000
`define UNIT_NS_X1000 1953125
`define UNIT_CYCLES 244140
`define PITCH_BASE_HZ 65536
`define PITCH_HALF_CYCLES 954
`define CARRIER_HZ 4000
`define CARRIER_HALF_CYCLES 15625
`define ROM_AW 13
`endif

/* File: logic/melody_pkg.sv */
// types for the melody and buzzer driver
package melody_pkg;
  typedef enum logic [1:0] {intermittent_1, intermittent_2, single_beep, continuous} buzz_mode_t;
  typedef enum logic [1:0] {idle, fetch, wait_data, play} play_state_t;
endpackage

/* File: logic/note_word_reg.sv */
// holder for the next note word fetched ahead of the playing note
`timescale 1ns/1ps
`default_nettype none
module note_word_reg
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data
);
  // data leave from a register
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_data <= 16'h0000;
    else if (i_ce && i_wr)
      o_data <= i_data;
  end
endmodule
`default_nettype wire

/* File: logic/tone_divider.sv */
// square wave divider: toggles every half period count
`timescale 1ns/1ps
`default_nettype none
module tone_divider
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [23:0] i_half,
  output logic o_wave
);
  logic [23:0] cnt_reg; // cycles counted so far in this half period
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      cnt_reg <= 24'h000000;
      o_wave <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!i_run)
      begin
        // idle keeps the phase known so every tone starts low
        cnt_reg <= 24'h000000;
        o_wave <= 1'b0;
      end
      else if (cnt_reg >= i_half - 24'h000001)
      begin
        cnt_reg <= 24'h000000;
        o_wave <= ~o_wave;
      end
      else
        cnt_reg <= cnt_reg + 24'h000001;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/melody_buzzer_driver_monitor.sv */
// concurrent checks on the melody and buzzer driver ports
`timescale 1ns/1ps
`default_nettype none
`include "melody_params.svh"
module melody_buzzer_monitor
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic i_melody_start_instruction,
  input wire logic [`ROM_AW-1:0] i_start_addr,
  input wire logic o_rom_req,
  input wire logic [`ROM_AW-1:0] o_rom_addr,
  input wire logic i_rom_valid,
  input wire logic o_melody_end_irq,
  input wire logic o_sounder_out_pin,
  input wire logic o_sounder_out_inv_pin
);
  // shortest half period, pitch code 4
  localparam int min_half = 5724;
  logic [3:0] tempo_reg; // last tempo written
  logic rd_reg; // tempo read taken last edge
  logic pin_reg; // pin at last edge
  logic full_reg; // a whole low phase is running
  logic [15:0] run_reg; // cycles since pin moved
  logic end_reg; // an end note was seen; a start then only queues
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // shadows; a start or silence drops phase tracking since phases restart there
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      tempo_reg <= 4'h0;
      rd_reg <= 1'b0;
      pin_reg <= 1'b0;
      full_reg <= 1'b0;
      run_reg <= 16'h0;
      end_reg <= 1'b0;
    end
    else
    begin
      if (o_melody_end_irq)
        end_reg <= 1'b1;
      else if (i_ce && i_write && i_address == `ADDR_CTRL && !i_writedata[`CTRL_PLAY_BIT])
        end_reg <= 1'b0;
      if (i_ce && i_write && i_address == `ADDR_BEAT_RATE)
        tempo_reg <= i_writedata[3:0];
      rd_reg <= i_ce && i_read && i_address == `ADDR_BEAT_RATE;
      pin_reg <= o_sounder_out_pin;
      run_reg <= (pin_reg != o_sounder_out_pin) ? 16'h0 : run_reg + {15'h0, ~&run_reg};
      if (i_melody_start_instruction || !(o_sounder_out_pin || o_sounder_out_inv_pin))
        full_reg <= 1'b0;
      else if (pin_reg && !o_sounder_out_pin)
        full_reg <= 1'b1;
    end
  end
  a_pins_complement: assert property (
    (o_sounder_out_pin || o_sounder_out_inv_pin) |-> o_sounder_out_pin != o_sounder_out_inv_pin)
    else $error("sounder pins not complementary");
  a_reset_quiet: assert property (
    !$past(i_nrst) |-> !(o_sounder_out_pin || o_sounder_out_inv_pin || o_melody_end_irq || o_rom_req))
    else $error("outputs active after reset");
  a_irq_one_cycle: assert property (
    o_melody_end_irq |=> !o_melody_end_irq)
    else $error("end interrupt longer than one cycle");
  a_start_fetch: assert property (
    i_ce && i_melody_start_instruction && !o_rom_req && !end_reg
      |=> o_rom_req && o_rom_addr == $past(i_start_addr))
    else $error("start did not fetch from start address");
  a_fetch_hold: assert property (
    o_rom_req && !i_rom_valid && !i_write && !i_melody_start_instruction
      |=> o_rom_req && $stable(o_rom_addr))
    else $error("fetch request dropped before data");
  a_stop_write: assert property (
    i_ce && i_write && i_address == `ADDR_CTRL && i_writedata[3:2] == 2'b00
      |-> ##[1:4] !(o_sounder_out_pin || o_sounder_out_inv_pin))
    else $error("output not stopped by control write");
  a_tempo_read: assert property (
    rd_reg |-> o_readdata[3:0] == tempo_reg)
    else $error("tempo read back wrong");
  a_half_min: assert property (
    $rose(o_sounder_out_pin) && full_reg |-> run_reg >= min_half - 1)
    else $error("tone half period too short");
  c_irq: cover property (o_melody_end_irq);
  c_full_half: cover property ($rose(o_sounder_out_pin) && full_reg);
  c_tempo_read: cover property (rd_reg);
endmodule
bind melody_buzzer_driver melody_buzzer_monitor mon (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
  .i_melody_start_instruction(i_melody_start_instruction), .i_start_addr(i_start_addr),
  .o_rom_req(o_rom_req), .o_rom_addr(o_rom_addr), .i_rom_valid(i_rom_valid),
  .o_melody_end_irq(o_melody_end_irq), .o_sounder_out_pin(o_sounder_out_pin),
  .o_sounder_out_inv_pin(o_sounder_out_inv_pin)
);
`default_nettype wire

/* File: testbench/note_rom_model.sv */
// program memory model answering the note fetch port
`timescale 1ns/1ps
`default_nettype none
`include "melody_params.svh"
module note_rom_model
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic [`ROM_AW-1:0] i_addr,
  input wire logic [3:0] i_lat,
  output logic o_valid,
  output logic [15:0] o_data
);
  logic [15:0] mem [0:8191]; // note table, loaded by the bench
  logic [3:0] cnt_reg; // wait cycles so far
  // answers after i_lat cycles; data churns otherwise so stale words never look valid
  always_ff @(posedge i_clk)
  begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    cnt_reg <= 4'h0;
    if (!i_nrst)
      o_data <= 16'h5a5a;
    else if (i_req && !o_valid)
    begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == i_lat)
      begin
        o_valid <= 1'b1;
        o_data <= mem[i_addr];
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_melody_buzzer_driver.sv */
// self-checking bench for the melody and buzzer driver
`timescale 1ns/1ps
`default_nettype none
`include "melody_params.svh"
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module test_melody_buzzer_driver;
  logic i_clk, i_nrst, i_read, i_write, start, valid, t8, t1, t32, waitreq, req, irq, pin, inv;
  logic ce; // clock enable, low freezes the design
  logic [1:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [12:0] saddr, raddr, fetch_addr;
  logic [15:0] rom_data;
  logic [3:0] lat;
  int num_errors = 0, n_checks = 0, seed = 32'h1605ee9b, h, n;
  melody_buzzer_driver dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_address(addr),
    .i_read(i_read), .i_write(i_write), .i_writedata(wdata), .o_readdata(rdata),
    .o_waitrequest(waitreq), .i_melody_start_instruction(start), .i_start_addr(saddr),
    .o_rom_req(req), .o_rom_addr(fetch_addr), .i_rom_valid(valid), .i_rom_data(rom_data),
    .i_tap_8hz(t8), .i_tap_1hz(t1), .i_tap_32hz(t32), .o_melody_end_irq(irq),
    .o_sounder_out_pin(pin), .o_sounder_out_inv_pin(inv));
  note_rom_model rom (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_addr(fetch_addr),
    .i_lat(lat), .o_valid(valid), .o_data(rom_data));
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one avalon transfer: held until waitrequest is seen low, data taken at that edge
  task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] v,
                     output logic [31:0] r);
    int k = 0;
    addr <= a;
    wdata <= v;
    i_write <= wr;
    i_read <= !wr;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (waitreq !== 1'b0 && k < 50);
    r = rdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    if (k >= 50)
    begin
      num_errors++;
      finish_test();
    end
    // an idle edge keeps the next call from touching the strobes in this step
    @(posedge i_clk);
  endtask
  // cycles until the sounder pin next moves
  task automatic wait_change(output int c);
    logic p = pin;
    c = 0;
    do
    begin
      @(posedge i_clk);
      c++;
    end
    while (pin === p && c < 40000);
    if (c >= 40000)
    begin
      num_errors++;
      finish_test();
    end
  endtask
  // gate expected from pattern mode and tap levels
  function automatic logic exp_sound(input int m, input logic a8, input logic a1);
    case (m)
      0: return a8;
      1: return a8 && !a1;
      default: return 1'b1;
    endcase
  endfunction
  initial
  begin
    {i_nrst, i_read, i_write, start, t8, t1, t32, addr, wdata, saddr, lat} = '0;
    ce = 1'b1;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    bus(`ADDR_CTRL, 1'b0, 32'h0, d);
    `CHK("ctrl reset", `CTRL_RESET, d[3:0])
    n = $random(seed) & 15;
    bus(`ADDR_BEAT_RATE, 1'b1, n, d);
    bus(`ADDR_BEAT_RATE, 1'b0, 32'h0, d);
    `CHK("tempo", n[3:0], d[3:0])
    // every pattern mode against every 8 Hz and 1 Hz tap combination
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 4; s++)
      begin
        bus(`ADDR_CTRL, 1'b1, 32'h0, d);
        t8 <= s[0];
        t1 <= s[1];
        bus(`ADDR_CTRL, 1'b1, 32'h4 | m, d);
        repeat (6) @(posedge i_clk);
        `CHK("buzz gate", exp_sound(m, s[0], s[1]), pin | inv)
      end
    // single beep lasts until the second fall of the 32 Hz tap
    bus(`ADDR_CTRL, 1'b1, 32'h0, d);
    bus(`ADDR_CTRL, 1'b1, 32'h6, d);
    for (int f = 1; f <= 2; f++)
    begin
      t32 <= 1'b1;
      repeat (6) @(posedge i_clk);
      t32 <= 1'b0;
      repeat (6) @(posedge i_clk);
      bus(`ADDR_CTRL, 1'b0, 32'h0, d);
      `CHK("beep enable", f == 1, d[2])
    end
    `CHK("beep over", 1'b0, pin | inv)
    bus(`ADDR_CTRL, 1'b1, 32'h7, d);
    wait_change(h);
    wait_change(h);
    `CHK("carrier half", `CARRIER_HALF_CYCLES, h)
    `CHK("inverse pin", ~pin, inv)
    // a frozen enable stretches the half period by exactly the frozen span
    ce <= 1'b0;
    repeat (100) @(posedge i_clk);
    ce <= 1'b1;
    wait_change(h);
    `CHK("frozen half", `CARRIER_HALF_CYCLES, h)
    // melody started over the running buzzer; its first note carries the end bit, stop words follow it
    n = 4 + ($random(seed) & 3);
    raddr = $random(seed) & 13'h0fff;
    rom.mem[raddr] = 16'h8000 | ((($random(seed) & 63) << 8) | n);
    rom.mem[raddr + 3] = 16'h8003;
    for (int w = 1; w < 7; w += 1 + (w == 2))
      rom.mem[raddr + w] = 16'h8000;
    lat <= $random(seed) & 7;
    saddr <= raddr;
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    h = 0;
    while (irq !== 1'b1 && h < 40)
    begin
      @(posedge i_clk);
      h++;
    end
    `CHK("end irq", 1'b1, irq)
    bus(`ADDR_CTRL, 1'b0, 32'h0, d);
    `CHK("ctrl playing", 4'hb, d[3:0])
    wait_change(h);
    wait_change(h);
    `CHK("pitch half", (n + 2) * `PITCH_HALF_CYCLES, h)
    bus(`ADDR_CTRL, 1'b1, 32'h0, d);
    bus(`ADDR_CTRL, 1'b0, 32'h0, d);
    `CHK("forced stop", 4'h0, {d[3], pin | inv})
    lat <= 4'h9;
    saddr <= raddr + 3;
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    repeat (300) @(posedge i_clk);
    `CHK("silent note", 1'b0, pin | inv)
    bus(`ADDR_CTRL, 1'b0, 32'h0, d);
    `CHK("rest playing", 4'h8, d[3:0])
    bus(`ADDR_CTRL, 1'b1, 32'h0, d);
    // register start path; status then shows an end note playing
    bus(`ADDR_START, 1'b1, {raddr + 13'h3, 4'h1}, d);
    repeat (30) @(posedge i_clk);
    bus(`ADDR_STATUS, 1'b0, 32'h0, d);
    `CHK("status", 3'h3, d[2:0])
    bus(`ADDR_CTRL, 1'b1, 32'h0, d);
    finish_test();
  end
endmodule
`default_nettype wire
